// >>> hdl/gprc_defines.vh
`ifndef GPRC_DEFINES_VH
`define GPRC_DEFINES_VH

`define GPRC_NPINS        24
`define GPRC_MODE_W       4
`define GPRC_MODE_ANALOG  4'h0
`define GPRC_MODE_IN_FLT  4'h4
`define GPRC_MODE_IN_PULL 4'h8
`define GPRC_MODE_OUT_PP  4'h1
`define GPRC_MODE_OUT_OD  4'h5
`define GPRC_MODE_ALT_PP  4'h9
`define GPRC_MODE_ALT_OD  4'hd
`define GPRC_MODE_RESET   4'h4

// Word offsets (byte addresses)
`define GPRC_ADR_IN       8'h00
`define GPRC_ADR_OUT      8'h04
`define GPRC_ADR_SET      8'h08
`define GPRC_ADR_CLR      8'h0c
`define GPRC_ADR_WAKE     8'h10
`define GPRC_ADR_CTRL     8'h14
`define GPRC_ADR_IRQ_STAT 8'h18
`define GPRC_ADR_IRQ_MASK 8'h1c
`define GPRC_ADR_CFG0     8'h20
`define GPRC_ADR_CFG1     8'h24
`define GPRC_ADR_CFG2     8'h28
`define GPRC_CFG_WORDS    3

// Control register fields
`define GPRC_CTRL_EXTREG  0
`define GPRC_CTRL_RESET   32'h0000_0001

// Pins with interrupt logic
`define GPRC_IRQ_PINS     24'h00_00ff
// Pins with a peripheral on the alternate output
`define GPRC_ALT_PINS     24'h3f_ffff

`endif

// >>> hdl/gprc_gpio.v
`timescale 1ns/1ps
`default_nettype none
`include "gprc_defines.vh"

// Functional notes
// - Twenty-four pins, each with its own selectable output, input or analog mode.
// - Conditioned input level always feeds input register and peripheral inputs.
// - Wake logic sees a pin only when its wake enable is set.
// - Interrupt-capable pins also feed their input level to interrupt logic.
// - Analog mode disconnects the digital input and forces it high.
// - Exactly one source drives each pin output at any time.
// - Normal modes: output register drives pin; alternate modes: peripheral drives; pin 7 follows deep sleep while GPRC_CTRL_EXTREG is set.
// - Input and analog modes disable the digital output driver, except on pin 7 while GPRC_CTRL_EXTREG is set.
// - Deep sleep pulls regulator pin low; wake releases it to pull-up.
// - Both internal regulators switch off during deep sleep.
// - Mode codes: 0 analog, 4 input, 8 pulled, 1 push-pull, 5 open-drain, 9 alternate.
// - Pulled input: output bit one selects pull-up, zero selects pull-down.
// - Alternate mode without an owning peripheral drives zero.
module gprc_gpio (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg         wb_ack_o,
  output wire        wb_err_o,
  input  wire [23:0] pin_i,
  output reg  [23:0] pin_o,
  output reg  [23:0] pin_oe_n_o,
  output reg  [23:0] pin_pull_up_o,
  output reg  [23:0] pin_pull_down_o,
  output reg  [23:0] pin_analog_o,
  output reg  [23:0] periph_in_o,
  input  wire [23:0] periph_out_i,
  output reg  [23:0] wake_level_o,
  output reg  [23:0] irq_level_o,
  input  wire        deep_sleep_i,
  output reg         ext_regulator_ctl_pin_o,
  output reg         ext_regulator_ctl_pin_oe_n_o,
  output reg         int_reg_1v8_en_o,
  output reg         int_reg_1v25_en_o,
  output wire        irq_o
);

  reg  [23:0] sync1;
  reg  [23:0] sync2;
  reg  [23:0] prev_in;
  reg  [23:0] pin_output_register;
  reg  [23:0] wake_en;
  reg  [31:0] ctrl;
  reg  [23:0] irq_stat;
  reg  [23:0] irq_mask;
  reg  [95:0] pin_mode_config;
  reg         sleep_s1;
  reg         sleep_s2;
  reg  [23:0] pin_input_register;
  reg  [23:0] next_out;
  reg  [31:0] rd_data;
  reg         hit;
  wire [23:0] edge_evt;
  wire        req;
  wire        wr;
  wire [7:0]  adr;
  wire [31:0] wmask;
  integer     k;

  localparam [23:0] ALT_PINS = `GPRC_ALT_PINS;
  localparam [23:0] IRQ_PINS = `GPRC_IRQ_PINS;

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr       = req & wb_we_i;
  assign adr      = wb_adr_i[7:0];
  assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wb_err_o = 1'b0;
  assign edge_evt = (pin_input_register ^ prev_in) & `GPRC_IRQ_PINS;
  assign irq_o    = |(irq_stat & irq_mask);

  // Two flops before any reader; first stage is read only by the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 24'h00_0000;
      sync2 <= 24'h00_0000;
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      sleep_s1 <= deep_sleep_i;
      sleep_s2 <= sleep_s1;
    end
  end

  // Per-pin datapath, one mode decoder each
  genvar g;
  generate
    for (g = 0; g < `GPRC_NPINS; g = g + 1) begin : g_pin
      wire [3:0] mode = pin_mode_config[4*g +: 4];
      wire       alt  = (mode == `GPRC_MODE_ALT_PP) || (mode == `GPRC_MODE_ALT_OD);
      wire       od   = (mode == `GPRC_MODE_OUT_OD) || (mode == `GPRC_MODE_ALT_OD);
      wire       outm = (mode == `GPRC_MODE_OUT_PP) || od || alt;
      wire       ana  = (mode == `GPRC_MODE_ANALOG);
      wire       src  = alt ? ALT_PINS[g] & periph_out_i[g]
                            : pin_output_register[g];
      wire       ovr  = (g == 7) && ctrl[`GPRC_CTRL_EXTREG];
      always @* begin
        pin_input_register[g] = ana ? 1'b1 : sync2[g];
      end
      always @(posedge clk_i) begin
        if (rst_i) begin
          pin_o[g]           <= 1'b0;
          pin_oe_n_o[g]      <= 1'b1;
          pin_pull_up_o[g]   <= 1'b0;
          pin_pull_down_o[g] <= 1'b0;
          pin_analog_o[g]    <= 1'b0;
          periph_in_o[g]     <= 1'b1;
          wake_level_o[g]    <= 1'b0;
          irq_level_o[g]     <= 1'b0;
        end else begin
          if (ovr) begin
            pin_o[g]      <= 1'b0;
            pin_oe_n_o[g] <= ~sleep_s2;
          end else begin
            pin_o[g]      <= od ? 1'b0 : src;
            pin_oe_n_o[g] <= ~outm | (od & src);
          end
          pin_pull_up_o[g]   <= ~ovr & (mode == `GPRC_MODE_IN_PULL) & pin_output_register[g];
          pin_pull_down_o[g] <= ~ovr & (mode == `GPRC_MODE_IN_PULL) & ~pin_output_register[g];
          pin_analog_o[g]    <= ana & ~ovr;
          periph_in_o[g]     <= pin_input_register[g];
          wake_level_o[g]    <= wake_en[g] & pin_input_register[g];
          irq_level_o[g]     <= IRQ_PINS[g] & pin_input_register[g];
        end
      end
    end
  endgenerate

  always @* begin
    ext_regulator_ctl_pin_o      = 1'b0;
    ext_regulator_ctl_pin_oe_n_o = pin_oe_n_o[7];
  end

  // Internal regulators off whenever deep sleep is requested
  always @(posedge clk_i) begin
    if (rst_i) begin
      int_reg_1v8_en_o  <= 1'b1;
      int_reg_1v25_en_o <= 1'b1;
    end else begin
      int_reg_1v8_en_o  <= ~sleep_s2;
      int_reg_1v25_en_o <= ~sleep_s2;
    end
  end

  always @* begin
    hit     = 1'b1;
    rd_data = 32'h0000_0000;
    case (adr)
      `GPRC_ADR_IN:       rd_data = {8'h00, pin_input_register};
      `GPRC_ADR_OUT:      rd_data = {8'h00, pin_output_register};
      `GPRC_ADR_SET:      rd_data = 32'h0000_0000;
      `GPRC_ADR_CLR:      rd_data = 32'h0000_0000;
      `GPRC_ADR_WAKE:     rd_data = {8'h00, wake_en};
      `GPRC_ADR_CTRL:     rd_data = ctrl;
      `GPRC_ADR_IRQ_STAT: rd_data = {8'h00, irq_stat};
      `GPRC_ADR_IRQ_MASK: rd_data = {8'h00, irq_mask};
      `GPRC_ADR_CFG0:     rd_data = pin_mode_config[31:0];
      `GPRC_ADR_CFG1:     rd_data = pin_mode_config[63:32];
      `GPRC_ADR_CFG2:     rd_data = pin_mode_config[95:64];
      default:            hit = 1'b0;
    endcase
    next_out = pin_output_register;
    if (wr && adr == `GPRC_ADR_OUT)
      next_out = (pin_output_register & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
    else if (wr && adr == `GPRC_ADR_SET)
      next_out = pin_output_register | (wb_dat_i[23:0] & wmask[23:0]);
    else if (wr && adr == `GPRC_ADR_CLR)
      next_out = pin_output_register & ~(wb_dat_i[23:0] & wmask[23:0]);
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o            <= 1'b0;
      wb_dat_o            <= 32'h0000_0000;
      pin_output_register <= 24'h00_0000;
      wake_en             <= 24'h00_0000;
      ctrl                <= `GPRC_CTRL_RESET;
      irq_stat            <= 24'h00_0000;
      irq_mask            <= 24'h00_0000;
      prev_in             <= 24'h00_0000;
      for (k = 0; k < `GPRC_NPINS; k = k + 1)
        pin_mode_config[4*k +: 4] <= `GPRC_MODE_RESET;
    end else begin
      wb_ack_o            <= req;
      wb_dat_o            <= (req & ~wb_we_i) ? rd_data : 32'h0000_0000;
      pin_output_register <= next_out;
      prev_in             <= pin_input_register;
      // Unmapped addresses still ack; reads give zero, writes vanish
      if (wr && adr == `GPRC_ADR_WAKE)
        wake_en <= (wake_en & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
      if (wr && adr == `GPRC_ADR_CTRL)
        ctrl <= {31'h0000_0000, (wb_sel_i[0] ? wb_dat_i[0] : ctrl[0])};
      if (wr && adr == `GPRC_ADR_IRQ_MASK)
        irq_mask <= (irq_mask & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
      if (wr && adr == `GPRC_ADR_CFG0)
        pin_mode_config[31:0] <= (pin_mode_config[31:0] & ~wmask) | (wb_dat_i & wmask);
      if (wr && adr == `GPRC_ADR_CFG1)
        pin_mode_config[63:32] <= (pin_mode_config[63:32] & ~wmask) | (wb_dat_i & wmask);
      if (wr && adr == `GPRC_ADR_CFG2)
        pin_mode_config[95:64] <= (pin_mode_config[95:64] & ~wmask) | (wb_dat_i & wmask);
      // Read clears, but a same-cycle edge survives
      if (req && !wb_we_i && adr == `GPRC_ADR_IRQ_STAT)
        irq_stat <= edge_evt;
      else
        irq_stat <= irq_stat | edge_evt;
    end
  end

endmodule
`default_nettype wire

// >>> tb/gprc_board.sv
`timescale 1ns/1ps
`default_nettype none
module gprc_board (
  input  wire logic        clk_i,
  input  wire logic [23:0] pin_o,
  input  wire logic [23:0] oe_n,
  input  wire logic [23:0] pu,
  input  wire logic [23:0] pd,
  input  wire logic [23:0] ext_v,
  input  wire logic [23:0] ext_en,
  output logic      [23:0] pin
);
  logic tog = 1'b0;
  always @(posedge clk_i) tog <= ~tog;
  // Floating pins wander, so no level is implied, except on pin 7, which the board pulls high
  always_comb
    for (int i = 0; i < 24; i++)
      pin[i] = !oe_n[i] ? pin_o[i] : ext_en[i] ? ext_v[i] :
               (pu[i] | (i == 7)) ? 1'b1 : pd[i] ? 1'b0 : tog;
endmodule
`default_nettype wire

// >>> tb/gprc_gpio_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gprc_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        deep_sleep_i,
  input wire logic [23:0] pin_oe_n_o,
  input wire logic [23:0] pin_analog_o,
  input wire logic [23:0] periph_in_o,
  input wire logic [23:0] irq_level_o,
  input wire logic        ext_regulator_ctl_pin_oe_n_o,
  input wire logic        int_reg_1v8_en_o,
  input wire logic        int_reg_1v25_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_analog_high: assert property ((($past(pin_analog_o, 3) & pin_analog_o) & ~periph_in_o)
    == 24'h00_0000) else $error("analog input low");
  a_analog_undriven: assert property ((pin_analog_o & ~pin_oe_n_o) == 24'h00_0000)
    else $error("analog pin driven");
  a_irq_pins_only: assert property (irq_level_o[23:8] == 16'h0000) else $error("irq pin");
  a_regs_off: assert property (deep_sleep_i [*4] |-> !int_reg_1v8_en_o && !int_reg_1v25_en_o)
    else $error("regulator on in sleep");
  a_regs_on: assert property (!deep_sleep_i [*4] |-> int_reg_1v8_en_o && int_reg_1v25_en_o)
    else $error("regulator off awake");
  a_ext_low: assert property (deep_sleep_i [*4] |-> !ext_regulator_ctl_pin_oe_n_o)
    else $error("ext pin released");
  a_ext_free: assert property (!deep_sleep_i [*4] |-> ext_regulator_ctl_pin_oe_n_o)
    else $error("ext pin held");
  c_bus: cover property (wb_ack_o);
  c_sleep: cover property (deep_sleep_i [*4]);
  c_analog: cover property (|pin_analog_o);
endmodule
bind gprc_gpio gprc_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .deep_sleep_i(deep_sleep_i),
  .pin_oe_n_o(pin_oe_n_o), .pin_analog_o(pin_analog_o), .periph_in_o(periph_in_o),
  .irq_level_o(irq_level_o), .ext_regulator_ctl_pin_oe_n_o(ext_regulator_ctl_pin_oe_n_o),
  .int_reg_1v8_en_o(int_reg_1v8_en_o), .int_reg_1v25_en_o(int_reg_1v25_en_o));
`default_nettype wire

// >>> tb/test_gprc_gpio.sv
`timescale 1ns/1ps
`default_nettype none
module test_gprc_gpio;
  logic        clk_i, rst_i, we, cyc, stb, slp, ack, xoe, r18, r125, irq;
  logic [31:0] adr, wd, rdat, q;
  logic [23:0] pin, po, oe_n, pu, pd, ana, pif, pout, wake, irql, ev, een;
  int          n_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  gprc_gpio dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .wb_err_o(), .pin_i(pin), .pin_o(po), .pin_oe_n_o(oe_n),
    .pin_pull_up_o(pu), .pin_pull_down_o(pd), .pin_analog_o(ana), .periph_in_o(pif),
    .periph_out_i(pout), .wake_level_o(wake), .irq_level_o(irql), .deep_sleep_i(slp),
    .ext_regulator_ctl_pin_o(), .ext_regulator_ctl_pin_oe_n_o(xoe),
    .int_reg_1v8_en_o(r18), .int_reg_1v25_en_o(r125), .irq_o(irq));
  gprc_board board_u (.clk_i(clk_i), .pin_o(po), .oe_n(oe_n), .pu(pu), .pd(pd),
    .ext_v(ev), .ext_en(een), .pin(pin));
  task automatic tally_and_finish;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    adr <= {24'h00_0000, a};
    we <= w;
    wd <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    {rst_i, we, cyc, stb, slp} = 5'b10000;
    {adr, wd} = 64'h0;
    {ev, een} = 48'h0;
    pout = 24'h40_0004;
    wt(3);
    rst_i <= 1'b0;
    wt(1);
    chk(oe_n, 24'hff_ffff);
    chk({r18, r125}, 2'b11);
    bus(8'h20, 1, 32'h4d48_0951);
    bus(8'h04, 1, 32'h0000_0013);
    bus(8'h28, 1, 32'h4944_4444);
    wt(4);
    chk(oe_n, 24'hbf_ffba);
    chk(po & ~oe_n, 24'h00_0005);
    chk({ana[3], pu[4], pd[4]}, 3'b110);
    bus(8'h0c, 1, 32'h0000_0010);
    een <= 24'h00_0020;
    ev <= 24'h00_0020;
    wt(4);
    chk({pu[4], pd[4]}, 2'b01);
    bus(8'h00, 0, 0);
    chk(q & 32'h28, 32'h28);
    chk(pif[5:3], 3'b101);
    chk(wake[5], 0);
    bus(8'h10, 1, 32'h20);
    bus(8'h1c, 1, 32'h20);
    wt(4);
    chk({wake[5], irql[5], irq}, 3'b111);
    bus(8'h18, 0, 0);
    chk(q & 32'h20, 32'h20);
    chk(irq, 0);
    slp <= 1'b1;
    wt(5);
    chk({r18, r125, xoe}, 3'b000);
    slp <= 1'b0;
    wt(5);
    chk({r18, r125, xoe}, 3'b111);
    bus(8'h40, 0, 0);
    chk(q, 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
